// ---- pkg/fmt_params.svh ----
// Purpose: Constants for the flash mode, level, trigger and timeout registers
// Assumes: 125 MHz system clock, 8-bit register port behind the serial decoder
// Notes:   Included by bare name; definitions only
`ifndef FMT_PARAMS_SVH
`define FMT_PARAMS_SVH

// -----------------------------------------------------------------
// Register addresses
// -----------------------------------------------------------------
`define FMT_ADDR_TORCH     8'ha0
`define FMT_ADDR_FLASH     8'hb0
`define FMT_ADDR_DUR       8'hc0

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define FMT_MODE_HI        2
`define FMT_MODE_LO        0
`define FMT_VOUT_BIT       2
`define FMT_EN_HI          1
`define FMT_TORCH_HI       7
`define FMT_TORCH_LO       3
`define FMT_LVL_HI         6
`define FMT_LVL_LO         3
`define FMT_TRIG_BIT       7
`define FMT_TIME_HI        4
`define FMT_TIME_LO        0
`define FMT_LIM_HI         6
`define FMT_LIM_LO         5
`define FMT_UNUSED_BIT     7

// -----------------------------------------------------------------
// Reset values and codes
// -----------------------------------------------------------------
`define FMT_MODE_RST       3'h0
`define FMT_TORCH_RST      5'h0a
`define FMT_LVL_RST        4'hd
`define FMT_TRIG_RST       1'h0
`define FMT_TIME_RST       5'h0f
`define FMT_LIM_RST        2'h2
`define FMT_EN_FLASH       2'h3
`define FMT_EN_OFF         2'h0
`define FMT_UNUSED_RD      1'h0
`define FMT_RD_NONE        8'h00

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define FMT_STEP_MS        32
`define FMT_CLK_KHZ        125000

`endif

// ---- pkg/fmt_pkg.sv ----
// Purpose: Types shared by the flash register block
// Assumes: Nothing beyond the params header
// Notes:   Used as fmt_pkg::name, never imported
package fmt_pkg;

  // -----------------------------------------------------------------
  // Flash sequencer states
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    FMT_IDLE = 2'b01,
    FMT_ON   = 2'b10
  } fmt_state_t;

  // -----------------------------------------------------------------
  // Mode field decode
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    FMT_M_SHUTDOWN  = 3'h0,
    FMT_M_INDICATOR = 3'h1,
    FMT_M_TORCH     = 3'h2,
    FMT_M_FLASH     = 3'h3,
    FMT_M_VOUT      = 3'h4,
    FMT_M_VOUT_IND  = 3'h5,
    FMT_M_VOUT_TRCH = 3'h6,
    FMT_M_VOUT_FLSH = 3'h7
  } fmt_mode_t;

endpackage

// ---- hw/fmt_sync.sv ----
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to clk_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module fmt_sync (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic pin_i,
  output logic      level_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  // -----------------------------------------------------------------
  // Stages
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      s1_q  <= 1'h0;
      s2_q  <= 1'h0;
      s3_q  <= 1'h0;
      lvl_q <= 1'h0;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A change counts only once two late stages agree
      if (s2_q == s3_q)
        lvl_q <= s3_q;
    end
  end

  assign level_o = lvl_q;

endmodule // fmt_sync

// ---- hw/fmt_flash_regs.sv ----
// Purpose: Flash mode, level, trigger, timeout and switch limit registers
// Assumes: Serial decoder delivers one register write per address+data pair
// Notes:   Strobe pin is asynchronous; all outputs are flops
`timescale 1ns/100ps
`include "fmt_params.svh"
module fmt_flash_regs #(
  parameter int unsigned STEP_CYCLES = `FMT_STEP_MS * `FMT_CLK_KHZ,
  parameter int unsigned PRE_W       = 22
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wr_addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       rd_en_i,
  input  wire logic [7:0] rd_addr_i,
  input  wire logic       strobe_i,
  output logic      [7:0] rd_data_o,
  output logic      [2:0] mode_o,
  output logic      [3:0] flash_level_o,
  output logic      [1:0] switch_limit_o,
  output logic            flash_on_o,
  output logic            timeout_o
);

  // -----------------------------------------------------------------
  // Elaboration checks
  // -----------------------------------------------------------------
  if (STEP_CYCLES < 2)
    $error("STEP_CYCLES must be at least 2");
  if (STEP_CYCLES > (64'h1 << PRE_W))
    $error("PRE_W too narrow for STEP_CYCLES");

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYCLES - 1);

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  logic [2:0]             mode_q;
  logic [2:0]             mode_d;
  logic [4:0]             torch_hi_q;
  logic [3:0]             level_q;
  logic                   trig_kind_q;
  logic [4:0]             time_code_q;
  logic [1:0]             limit_q;
  logic [7:0]             rd_data_q;
  logic                   on_q;
  logic                   timeout_q;
  logic                   strobe_prev_q;
  logic [PRE_W-1:0]       pre_q;
  logic [4:0]             step_q;
  fmt_pkg::fmt_state_t    state_q;
  fmt_pkg::fmt_state_t    state_d;

  // -----------------------------------------------------------------
  // Strobe pin
  // -----------------------------------------------------------------
  logic strobe_lvl;

  fmt_sync u_strobe_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (strobe_i),
    .level_o   (strobe_lvl)
  );

  // -----------------------------------------------------------------
  // Decode
  // -----------------------------------------------------------------
  wire wr_torch = wr_en_i && (wr_addr_i == `FMT_ADDR_TORCH);
  wire wr_flash = wr_en_i && (wr_addr_i == `FMT_ADDR_FLASH);
  wire wr_dur   = wr_en_i && (wr_addr_i == `FMT_ADDR_DUR);
  wire rd_torch = (rd_addr_i == `FMT_ADDR_TORCH);
  wire rd_flash = (rd_addr_i == `FMT_ADDR_FLASH);
  wire rd_dur   = (rd_addr_i == `FMT_ADDR_DUR);

  // Flash current only in modes whose enable bits read flash
  wire mode_is_flash = (mode_q[`FMT_EN_HI:0] == `FMT_EN_FLASH);
  wire strobe_rise   = strobe_lvl && !strobe_prev_q;
  wire is_idle       = (state_q == fmt_pkg::FMT_IDLE);
  wire is_on         = (state_q == fmt_pkg::FMT_ON);
  wire start         = is_idle && mode_is_flash && strobe_rise;
  wire step_tick     = is_on && (pre_q == PRE_LAST);
  // Duration is (code + 1) steps of 32 ms
  wire expire        = step_tick && (step_q == time_code_q);
  // Level mode ends early when the strobe falls
  wire early_stop    = is_on && !trig_kind_q && !strobe_lvl;
  wire host_stop     = is_on && !mode_is_flash;

  // -----------------------------------------------------------------
  // Mode field: shared by both registers, timeout clears the enable bits of a write
  // -----------------------------------------------------------------
  wire [2:0] mode_wr =
    wr_flash ? wr_data_i[`FMT_MODE_HI:`FMT_MODE_LO] :
    wr_torch ? wr_data_i[`FMT_MODE_HI:`FMT_MODE_LO] :
               mode_q;

  always_comb
  begin
    mode_d = mode_wr;
    // Expiry keeps the voltage bit and drops the enable bits
    if (expire)
      mode_d = {mode_wr[`FMT_VOUT_BIT], `FMT_EN_OFF};
  end

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      fmt_pkg::FMT_IDLE:
        if (start)
          state_d = fmt_pkg::FMT_ON;
      fmt_pkg::FMT_ON:
        if (expire || early_stop || host_stop)
          state_d = fmt_pkg::FMT_IDLE;
      default:
        state_d = fmt_pkg::FMT_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_q       <= fmt_pkg::FMT_IDLE;
      on_q          <= 1'h0;
      timeout_q     <= 1'h0;
      strobe_prev_q <= 1'h0;
    end
    else
    begin
      state_q       <= state_d;
      on_q          <= (state_d == fmt_pkg::FMT_ON);
      timeout_q     <= expire;
      strobe_prev_q <= strobe_lvl;
    end
  end

  // -----------------------------------------------------------------
  // Timeout timer: prescaler of 32 ms steps, then step count
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || start || !is_on)
    begin
      pre_q  <= '0;
      step_q <= 5'h0;
    end
    else if (step_tick)
    begin
      pre_q  <= '0;
      step_q <= step_q + 5'h1;
    end
    else
      pre_q <= pre_q + PRE_W'(1);
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      mode_q      <= `FMT_MODE_RST;
      torch_hi_q  <= `FMT_TORCH_RST;
      level_q     <= `FMT_LVL_RST;
      trig_kind_q <= `FMT_TRIG_RST;
      time_code_q <= `FMT_TIME_RST;
      limit_q     <= `FMT_LIM_RST;
    end
    else
    begin
      mode_q <= mode_d;
      if (wr_torch)
        torch_hi_q <= wr_data_i[`FMT_TORCH_HI:`FMT_TORCH_LO];
      if (wr_flash)
      begin
        level_q     <= wr_data_i[`FMT_LVL_HI:`FMT_LVL_LO];
        trig_kind_q <= wr_data_i[`FMT_TRIG_BIT];
      end
      // Top bit of the write is dropped
      if (wr_dur)
      begin
        time_code_q <= wr_data_i[`FMT_TIME_HI:`FMT_TIME_LO];
        limit_q     <= wr_data_i[`FMT_LIM_HI:`FMT_LIM_LO];
      end
    end
  end

  // -----------------------------------------------------------------
  // Read path: one cycle after rd_en_i
  // -----------------------------------------------------------------
  wire [7:0] rd_mux =
    rd_torch ? {torch_hi_q, mode_q} :
    rd_flash ? {trig_kind_q, level_q, mode_q} :
    rd_dur   ? {`FMT_UNUSED_RD, limit_q, time_code_q} :
               `FMT_RD_NONE;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      rd_data_q <= `FMT_RD_NONE;
    else if (rd_en_i)
      rd_data_q <= rd_mux;
  end

  assign rd_data_o      = rd_data_q;
  assign mode_o         = mode_q;
  assign flash_level_o  = level_q;
  assign switch_limit_o = limit_q;
  assign flash_on_o     = on_q;
  assign timeout_o      = timeout_q;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  mode_decode_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    on_q |-> $past(mode_is_flash)
  ) else $error("flash on outside flash mode");

  mirror_flash_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (wr_flash && !expire) |=> (mode_o == $past(wr_data_i[2:0]))
  ) else $error("flash mode write not mirrored");

  mirror_read_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (rd_en_i && rd_torch) |=> (rd_data_o[2:0] == $past(mode_q))
  ) else $error("torch read does not show shared mode");

  mirror_torch_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (wr_torch && !expire) |=> (mode_o == $past(wr_data_i[2:0]))
  ) else $error("torch mode write not mirrored");

  timeout_clear_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    expire |=> timeout_o && (mode_o[1:0] == 2'h0) && !flash_on_o
      && (mode_o[2] == $past(mode_wr[2]))
  ) else $error("timeout did not clear enable bits");

  level_reset_a: assert property (
    @(posedge clk_i)
    sys_rst_i |=> (flash_level_o == 4'hd) && (mode_o == 3'h0)
  ) else $error("flash level reset wrong");

  level_stop_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (is_on && !trig_kind_q && !strobe_lvl) |=> !flash_on_o ##1 !flash_on_o
  ) else $error("level mode did not stop on strobe low");

  edge_hold_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (is_on && trig_kind_q && !expire && mode_is_flash) |=> flash_on_o
  ) else $error("edge mode flash ended early");

  timer_restart_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    start |=> (pre_q == '0) && (step_q == 5'h0) && flash_on_o
  ) else $error("timer did not restart");

  step_limit_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    is_on |-> (step_q <= time_code_q) || $past(wr_dur)
  ) else $error("step count passed duration code");

  time_reset_a: assert property (
    @(posedge clk_i)
    sys_rst_i |=> (time_code_q == 5'h0f) && (switch_limit_o == 2'h2)
  ) else $error("duration reset wrong");

  limit_write_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    wr_dur |=> (switch_limit_o == $past(wr_data_i[6:5]))
  ) else $error("switch limit not written");

  unused_bit_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (rd_en_i && rd_dur) |=> (rd_data_o[7] == 1'h0)
  ) else $error("unused duration bit reads one");

endmodule // fmt_flash_regs

// ---- sim/fmt_host_model.sv ----
// Purpose: Host and strobe source driving the flash register port
// Assumes: Decoded byte port; one access per task call
// Notes:   Every line changes 1 ns after a rising edge
`timescale 1ns/100ps
module fmt_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rd_data_i,
  output logic            wr_en_o,
  output logic      [7:0] wr_addr_o,
  output logic      [7:0] wr_data_o,
  output logic            rd_en_o,
  output logic      [7:0] rd_addr_o,
  output logic            strobe_o
);
  initial
  begin
    wr_en_o   = 1'b0;
    wr_addr_o = 8'h00;
    wr_data_o = 8'h00;
    rd_en_o   = 1'b0;
    rd_addr_o = 8'h00;
    strobe_o  = 1'b0;
  end

  // -----------------------------------------------------------------
  // Accesses
  // -----------------------------------------------------------------
  // Released lines are inverted so a stale address or byte cannot pass
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    #1;
    wr_en_o   = 1'b1;
    wr_addr_o = addr;
    wr_data_o = data;
    @(posedge clk_i);
    #1;
    wr_en_o   = 1'b0;
    wr_addr_o = ~addr;
    wr_data_o = ~data;
  endtask

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_i);
    #1;
    rd_en_o   = 1'b1;
    rd_addr_o = addr;
    @(posedge clk_i);
    #1;
    rd_en_o   = 1'b0;
    rd_addr_o = ~addr;
    data      = rd_data_i;
  endtask

  // Pulses shorter than two cycles would be eaten by the pin filter
  task automatic strobe_pulse(input int cycles);
    @(posedge clk_i);
    #1;
    strobe_o = 1'b1;
    repeat (cycles) @(posedge clk_i);
    #1;
    strobe_o = 1'b0;
  endtask
endmodule // fmt_host_model

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the flash register block
// Assumes: Timer step shortened to 8 cycles
// Notes:   Each scenario is one task
`timescale 1ns/100ps
`include "fmt_params.svh"
module tb_top;
  localparam int unsigned STEP = 8;
  logic       clk_i     = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       rd_en;
  logic [7:0] rd_addr;
  logic       strobe;
  logic [7:0] rd_data;
  logic [2:0] mode;
  logic [3:0] level;
  logic [1:0] limit;
  logic       flash_on;
  logic       timeout_p;
  int         num_errors = 0;
  int         num_checks = 0;
  int         cyc        = 0;

  always #4 clk_i = ~clk_i;

  fmt_flash_regs #(.STEP_CYCLES(STEP)) uut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wr_en_i(wr_en), .wr_addr_i(wr_addr),
    .wr_data_i(wr_data), .rd_en_i(rd_en), .rd_addr_i(rd_addr), .strobe_i(strobe),
    .rd_data_o(rd_data), .mode_o(mode), .flash_level_o(level), .switch_limit_o(limit),
    .flash_on_o(flash_on), .timeout_o(timeout_p));

  fmt_host_model host (
    .clk_i(clk_i), .rd_data_i(rd_data), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .rd_en_o(rd_en), .rd_addr_o(rd_addr), .strobe_o(strobe));

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  task automatic stop_test();
    if (num_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(addr, d);
    chk(d, exp);
  endtask

  // Counts flash-on cycles and notes a timeout pulse at the end
  task automatic measure(output int n, output logic to);
    n  = 0;
    to = 1'b0;
    for (int i = 0; i < 20 && flash_on !== 1'b1; i++)
    begin
      @(posedge clk_i);
      #1;
    end
    while (flash_on === 1'b1 && n < 300)
    begin
      n++;
      @(posedge clk_i);
      #1;
      if (timeout_p === 1'b1)
        to = 1'b1;
    end
  endtask

  task automatic flash(input int hold, output int n, output logic to);
    fork
      host.strobe_pulse(hold);
      measure(n, to);
    join
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_reset();
    chk({5'h00, mode}, 8'h00);
    chk({4'h0, level}, 8'h0d);
    chk({6'h00, limit}, 8'h02);
    rchk(`FMT_ADDR_TORCH, 8'h50);
    rchk(`FMT_ADDR_FLASH, 8'h68);
    rchk(`FMT_ADDR_DUR, 8'h4f);
    rchk(8'hd0, 8'h00);
  endtask

  task automatic t_modes();
    for (int m = 0; m < 8; m++)
    begin
      host.wr(`FMT_ADDR_FLASH, {5'h0d, 3'(m)});
      chk({5'h00, mode}, 8'(m));
      rchk(`FMT_ADDR_TORCH, {5'h0a, 3'(m)});
    end
    host.wr(`FMT_ADDR_TORCH, 8'hfe);
    chk({5'h00, mode}, 8'h06);
    rchk(`FMT_ADDR_FLASH, 8'h6e);
  endtask

  task automatic t_fields();
    for (int l = 0; l < 16; l++)
    begin
      host.wr(`FMT_ADDR_FLASH, {1'b1, 4'(l), 3'h5});
      chk({4'h0, level}, 8'(l));
    end
    rchk(`FMT_ADDR_FLASH, 8'hfd);
    for (int c = 0; c < 4; c++)
    begin
      host.wr(`FMT_ADDR_DUR, {1'b1, 2'(c), 5'(c * 7)});
      chk({6'h00, limit}, 8'(c));
      rchk(`FMT_ADDR_DUR, {1'b0, 2'(c), 5'(c * 7)});
    end
  endtask

  task automatic t_edge();
    int   n;
    logic to;
    host.wr(`FMT_ADDR_DUR, 8'h42);
    host.wr(`FMT_ADDR_FLASH, 8'he3);
    flash(6, n, to);
    chk(8'(n), 8'(3 * STEP));
    chk({7'h00, to}, 8'h01);
    chk({5'h00, mode}, 8'h00);
    rchk(`FMT_ADDR_TORCH, 8'hf8);
  endtask

  task automatic t_level();
    int   n;
    logic to;
    host.wr(`FMT_ADDR_DUR, 8'h41);
    host.wr(`FMT_ADDR_FLASH, 8'h6f);
    flash(6, n, to);
    chk({7'h00, (n > 0 && n < 16)}, 8'h01);
    chk({7'h00, to}, 8'h00);
    chk({5'h00, mode}, 8'h07);
    // A second flash must get the whole duration, not the leftover
    flash(40, n, to);
    chk(8'(n), 8'(2 * STEP));
    chk({7'h00, to}, 8'h01);
    chk({5'h00, mode}, 8'h04);
    host.wr(`FMT_ADDR_FLASH, 8'h6a);
    flash(6, n, to);
    chk(8'(n), 8'h00);
  endtask

  // -----------------------------------------------------------------
  // Sequence and hang guard
  // -----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      stop_test();
    end
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    t_reset();
    t_modes();
    t_fields();
    t_edge();
    t_level();
    stop_test();
  end
endmodule // tb_top
